// file: amd_address_map_decoder.sv
// Purpose: Address folding, window decode, vectors and expansion pins
// Assumes: Straps stable; peripheral accesses come as single requests
// Notes:   Registers on APB; peripheral word access split in two halves
`timescale 1ns/1ps

// Functional notes
// - Both straps low: 16-bit bus, 07H
// - Upper low, lower high: 8-bit, 0FH
// - Ignore upper six CPU address bits
// - PC top bits zero, carry dropped
// - Data address sum wraps at 32 bits
// - RAM window at 3FFE000H, 4 KB
// - Peripheral registers in 4 KB at 3FFF000H
// - Fixed vectors for reset, NMI, traps, illegal
// - Peripheral vectors 16-byte spaced, 80H to 400H
// - Peripheral decode ignores address bit 0
// - Word access becomes low then high halfword
// - Halfword on byte register: low byte only
// - External range with reserved hole, chip selects
// - Internal windows never start external cycles
// - Chip select per block, none for special
// - Expansion register byte/bit access, top zero
// - Field selects address lines and upper byte
// - Widest setting reaches 16 MB external
module amd_address_map_decoder
  import amd_pkg::*;
#(
  parameter int NUM_PERIPH_VEC = 64
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Mode straps
  input  wire logic        strapSelectLow,
  input  wire logic        strapSelectHigh,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // CPU data path
  input  wire logic        dataReq,
  input  wire logic        dataWrite,
  input  wire logic [1:0]  dataSize,
  input  wire logic [31:0] dataBase,
  input  wire logic [31:0] dataDisp,
  input  wire logic [31:0] dataWdata,
  output logic [31:0]      dataRdata,
  output logic             dataDone,
  // CPU fetch path
  input  wire logic [31:0] pcBase,
  input  wire logic [31:0] pcOffset,
  output logic [31:0]      pcTarget,
  output logic             pcInPeriph,
  // Exception vectoring
  input  wire logic        excReq,
  input  wire amd_exc_t    excKind,
  input  wire logic [6:0]  periphIndex,
  output logic [31:0]      vectorAddr,
  output logic             vectorValid,
  // Target selects
  output logic [25:0]      physAddr,
  output logic             selRam,
  output logic             selPeriph,
  output logic             extStart,
  output logic [NUM_CS-1:0] chipSel,
  // Peripheral halfword bus
  output logic             perReq,
  output logic             perWrite,
  output logic [11:0]      perAddr,
  output logic [15:0]      perWdata,
  output logic             perByteReg,
  input  wire logic [15:0] perRdata,
  input  wire logic        perIsByteReg,
  // Pin function outputs
  output logic [7:0]       expansionPinControl,
  output logic             upperDataIsBus,
  output logic [7:0]       upperAddrEnable,
  output logic             modeProhibited,
  output logic             busWide16
);
  logic [7:0]  expReg;
  logic [7:0]  expNext;
  logic        modeWide;
  logic        prohibited;
  logic        initDone;
  logic [31:0] cpuAddr;
  logic [25:0] phys;
  logic        inRam;
  logic        inPio;
  logic        inRsv;
  logic        inExt;
  amd_word_t   wordState;
  logic [31:0] wordRdata;

  // Straps caught after reset release, not by the reset itself
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      initDone   <= 1'b0;
      modeWide   <= 1'b1;
      prohibited <= 1'b0;
    end else if (!initDone) begin
      initDone   <= 1'b1;
      modeWide   <= !strapSelectLow;
      prohibited <= strapSelectHigh;
    end
  end

  // Expansion register: reset value by strap, byte or bit writes
  always_comb begin
    expNext = expReg;
    if (!initDone) begin
      expNext = strapSelectLow ? EXP_RESET_M1 : EXP_RESET_M0;
    end else if (psel && penable && pwrite && paddr == APB_EXP_OFS && pstrb[0]) begin
      expNext = {4'h0, pwdata[3:0]};
    end else if (dataDone && dataWrite && inPio && phys[11:1] == EXP_REG_OFS[11:1]) begin
      expNext = {4'h0, dataWdata[3:0]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      expReg <= EXP_RESET_M0;
    end else begin
      expReg <= expNext;
    end
  end

  assign expansionPinControl = expReg;
  assign busWide16           = modeWide;
  assign modeProhibited      = prohibited;
  assign upperDataIsBus      = !expReg[EXP_REL_BIT];

  // Address lines A16..A23 enabled in pairs from field value 4 upward
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gAddr
      assign upperAddrEnable[g] = (expReg[2:0] >= 3'(4 + g / 2));
    end
  endgenerate

  // APB slave, zero wait states
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr >= APB_LAST_OFS);

  always_comb begin
    prdata = 32'h00000000;
    if (paddr == APB_EXP_OFS) begin
      prdata = {24'h000000, expReg};
    end else if (paddr == APB_STAT_OFS) begin
      prdata = {29'h0, initDone, prohibited, modeWide};
    end
  end

  // Data address wraps at 32 bits; top six bits folded away
  assign cpuAddr  = dataBase + dataDisp;
  assign phys     = cpuAddr[25:0];
  assign physAddr = phys;

  assign inRam = (phys >= RAM_BASE) && (phys <= RAM_LAST);
  assign inPio = (phys >= PIO_BASE) && (phys <= PIO_LAST);
  assign inRsv = (phys >= RSV_BASE) && (phys <= RSV_LAST);
  assign inExt = !inRam && !inPio && !inRsv && (phys <= EXT_LAST);

  assign selRam    = dataReq && inRam;
  assign selPeriph = dataReq && inPio;
  assign extStart  = dataReq && inExt;

  // Top block has no chip select; external logic decodes it
  generate
    for (g = 0; g < NUM_CS; g++) begin : gCs
      if (g == NUM_CS - 1) begin : gNone
        assign chipSel[g] = 1'b0;
      end else begin : gSel
        assign chipSel[g] = extStart && (phys[PHYS_W-1:CS_SHIFT] == 3'(g));
      end
    end
  endgenerate

  // Program counter stays inside 64 MB
  always_comb begin
    logic [31:0] sum;
    sum        = pcBase + pcOffset;
    pcTarget   = {6'h00, sum[25:1], 1'b0};
    pcInPeriph = (sum[25:0] >= PIO_BASE);
  end

  // Vector table
  always_comb begin
    vectorAddr  = VEC_RESET;
    vectorValid = excReq;
    case (excKind)
      EXC_RESET:   vectorAddr = VEC_RESET;
      EXC_NMI:     vectorAddr = VEC_NMI;
      EXC_TRAP_A:  vectorAddr = VEC_TRAP_A;
      EXC_TRAP_B:  vectorAddr = VEC_TRAP_B;
      EXC_ILLEGAL: vectorAddr = VEC_ILLEGAL;
      EXC_PERIPH: begin
        vectorAddr = VEC_TIMER_OVF + VEC_STEP * {25'h0, periphIndex};
        if (vectorAddr > VEC_CONV_DONE || periphIndex >= 7'(NUM_PERIPH_VEC)) begin
          vectorValid = 1'b0;
        end
      end
      default:     vectorValid = 1'b0;
    endcase
  end

  // Peripheral halfword sequencer; word access split low then high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wordState <= WS_IDLE;
      wordRdata <= 32'h00000000;
    end else begin
      case (wordState)
        WS_IDLE: begin
          if (selPeriph) begin
            wordState <= WS_LOW;
          end
        end
        WS_LOW: begin
          wordRdata[15:0] <= perRdata;
          wordState       <= (dataSize == 2'd2) ? WS_HIGH : WS_IDLE;
        end
        WS_HIGH: begin
          wordRdata[31:16] <= perRdata;
          wordState        <= WS_IDLE;
        end
        default: wordState <= WS_IDLE;
      endcase
    end
  end

  assign perReq     = (wordState != WS_IDLE);
  assign perWrite   = dataWrite;
  assign perByteReg = perIsByteReg;
  always_comb begin
    perAddr  = {phys[11:2], wordState == WS_HIGH, 1'b0};
    if (dataSize != 2'd2) begin
      perAddr = {phys[11:1], 1'b0};
    end
    perWdata = (wordState == WS_HIGH) ? dataWdata[31:16] : dataWdata[15:0];
    if (perIsByteReg) begin
      perWdata = {8'h00, perWdata[7:0]};
    end
  end

  assign dataDone = (wordState == WS_HIGH) || (wordState == WS_LOW && dataSize != 2'd2);

  // Read data: byte registers leave the upper byte unspecified (zero here on byte and halfword reads, passed through on word reads)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dataRdata <= 32'h00000000;
    end else if (wordState == WS_HIGH) begin
      dataRdata <= {perRdata, wordRdata[15:0]};
    end else if (wordState == WS_LOW && dataSize != 2'd2) begin
      dataRdata <= {16'h0000, perIsByteReg ? 8'h00 : perRdata[15:8], perRdata[7:0]};
    end
  end

  // Checks
  sequence sWordLow;
    wordState == WS_LOW && dataSize == 2'd2;
  endsequence

  sequence sWordStart;
    wordState == WS_IDLE && selPeriph && dataSize == 2'd2;
  endsequence

  a_straps_wide: assert property (@(posedge clk) disable iff (rst)
    $rose(initDone) |-> (expReg == ($past(strapSelectLow) ? EXP_RESET_M1 : EXP_RESET_M0)))
    else $error("expansion reset value wrong");
  a_upper_release: assert property (@(posedge clk) disable iff (rst)
    upperDataIsBus == !expReg[3])
    else $error("upper data byte release wrong");
  a_phys_fold: assert property (@(posedge clk) disable iff (rst)
    physAddr == cpuAddr[25:0])
    else $error("physical fold wrong");
  a_pc_top: assert property (@(posedge clk) disable iff (rst)
    pcTarget[31:26] == 6'h00)
    else $error("pc upper bits set");
  a_ram_window: assert property (@(posedge clk) disable iff (rst)
    selRam |-> physAddr[25:12] == 14'h3FFE)
    else $error("ram select outside window");
  a_ext_exclusive: assert property (@(posedge clk) disable iff (rst)
    extStart |-> !selRam && !selPeriph)
    else $error("external cycle on internal window");
  a_word_split: assert property (@(posedge clk) disable iff (rst)
    sWordLow |=> wordState == WS_HIGH && perAddr[1] == 1'b1)
    else $error("word access not split");
  a_reg_top_zero: assert property (@(posedge clk) disable iff (rst)
    expReg[7:4] == 4'h0)
    else $error("expansion top bits nonzero");

  // Strap capture
  a_straps_narrow: assert property (@(posedge clk) disable iff (rst)
    $rose(initDone) |-> (modeWide == !$past(strapSelectLow)))
    else $error("bus width strap wrong");
  a_mode_prohib: assert property (@(posedge clk) disable iff (rst)
    $rose(initDone) |-> (prohibited == $past(strapSelectHigh)))
    else $error("prohibited flag wrong");
  a_narrow_reset: assert property (@(posedge clk) disable iff (rst)
    $rose(initDone) && !modeWide |-> expReg == EXP_RESET_M1)
    else $error("narrow mode reset value wrong");

  // Fetch and data address folding
  a_pc_even: assert property (@(posedge clk) disable iff (rst)
    pcTarget[0] == 1'b0)
    else $error("pc target odd");
  a_pc_periph: assert property (@(posedge clk) disable iff (rst)
    pcInPeriph == (pcTarget[25:12] == 14'h3FFF))
    else $error("pc periph flag wrong");
  a_data_wrap: assert property (@(posedge clk) disable iff (rst)
    physAddr == 26'(dataBase + dataDisp))
    else $error("data address wrap wrong");

  // Window decode
  a_pio_window: assert property (@(posedge clk) disable iff (rst)
    selPeriph |-> physAddr[25:12] == 14'h3FFF)
    else $error("periph select outside window");
  a_ram_only: assert property (@(posedge clk) disable iff (rst)
    dataReq && physAddr[25:12] == 14'h3FFE |-> selRam)
    else $error("ram window not selected");
  a_ext_range: assert property (@(posedge clk) disable iff (rst)
    extStart |-> physAddr <= EXT_LAST)
    else $error("external cycle above range");
  a_ext_hole: assert property (@(posedge clk) disable iff (rst)
    extStart |-> !(physAddr >= RSV_BASE && physAddr <= RSV_LAST))
    else $error("external cycle in reserved span");
  a_one_target: assert property (@(posedge clk) disable iff (rst)
    $onehot0({selRam, selPeriph, extStart}))
    else $error("more than one target");
  a_cs_onehot: assert property (@(posedge clk) disable iff (rst)
    $onehot0(chipSel))
    else $error("several chip selects");
  a_cs_gated: assert property (@(posedge clk) disable iff (rst)
    chipSel != '0 |-> extStart)
    else $error("chip select without external cycle");
  a_cs_top_none: assert property (@(posedge clk) disable iff (rst)
    !chipSel[NUM_CS-1])
    else $error("top block chip select driven");

  // Vectors
  a_vec_fixed: assert property (@(posedge clk) disable iff (rst)
    excReq && excKind == EXC_NMI |-> vectorValid && vectorAddr == VEC_NMI)
    else $error("nmi vector wrong");
  a_vec_periph: assert property (@(posedge clk) disable iff (rst)
    vectorValid && excKind == EXC_PERIPH |-> vectorAddr[3:0] == 4'h0 && vectorAddr >= VEC_TIMER_OVF
      && vectorAddr <= VEC_CONV_DONE)
    else $error("peripheral vector out of table");

  // Peripheral halfword bus
  a_per_even: assert property (@(posedge clk) disable iff (rst)
    perReq |-> perAddr[0] == 1'b0)
    else $error("peripheral address odd");
  a_byte_write: assert property (@(posedge clk) disable iff (rst)
    perReq && perWrite && perIsByteReg |-> perWdata[15:8] == 8'h00)
    else $error("byte register upper byte written");
  a_word_order: assert property (@(posedge clk) disable iff (rst)
    sWordStart |=> (perReq && !perAddr[1]) ##1 (perReq && perAddr[1]))
    else $error("word halves out of order");
  a_done_pulse: assert property (@(posedge clk) disable iff (rst)
    dataDone |=> !dataDone)
    else $error("done longer than one cycle");

  // Expansion pins and register, APB offset errors
  a_upper_lines: assert property (@(posedge clk) disable iff (rst)
    expReg[2:0] == 3'h7 |-> upperAddrEnable == 8'hFF)
    else $error("widest setting lines missing");
  a_lines_none: assert property (@(posedge clk) disable iff (rst)
    expReg[2:0] < 3'h4 |-> upperAddrEnable == 8'h00)
    else $error("upper lines driven too early");
  a_apb_write: assert property (@(posedge clk) disable iff (rst)
    initDone && psel && penable && pwrite && paddr == APB_EXP_OFS && pstrb[0]
      |=> expReg == {4'h0, $past(pwdata[3:0])})
    else $error("expansion write lost");
  a_expreg_hold: assert property (@(posedge clk) disable iff (rst)
    initDone && !(psel && penable && pwrite && paddr == APB_EXP_OFS && pstrb[0])
      && !(dataDone && dataWrite && physAddr[25:12] == 14'h3FFF) |=> $stable(expReg))
    else $error("expansion register changed unasked");
  a_apb_err: assert property (@(posedge clk) disable iff (rst)
    psel && penable && paddr >= APB_LAST_OFS |-> pslverr && prdata == 32'h00000000)
    else $error("undefined offset not refused");
endmodule

// file: amd_pkg.sv
// Purpose: Constants for the address map decoder
// Assumes: 32-bit CPU addresses, 26-bit physical space
// Notes:   Shared by the decoder top and its bench
package amd_pkg;
  localparam int          PHYS_W         = 26;
  localparam logic [25:0] RAM_BASE       = 26'h3FFE000;
  localparam logic [25:0] RAM_LAST       = 26'h3FFEFFF;
  localparam logic [25:0] PIO_BASE       = 26'h3FFF000;
  localparam logic [25:0] PIO_LAST       = 26'h3FFFFFF;
  localparam logic [25:0] EXT_LAST       = 26'h3FFDFFF;
  localparam logic [25:0] RSV_BASE       = 26'h1000000;
  localparam logic [25:0] RSV_LAST       = 26'h2FFFFFF;
  // Expansion register inside the peripheral window
  localparam logic [11:0] EXP_REG_OFS    = 12'h04C;
  localparam logic [31:0] EXP_REG_ADDR   = 32'hFFFFF04C;
  localparam logic [7:0]  EXP_RESET_M0   = 8'h07;
  localparam logic [7:0]  EXP_RESET_M1   = 8'h0F;
  localparam int          EXP_SEL_LSB    = 0;
  localparam int          EXP_REL_BIT    = 3;
  // APB offsets of block-local registers
  localparam logic [11:0] APB_EXP_OFS    = 12'h000;
  localparam logic [11:0] APB_STAT_OFS   = 12'h004;
  localparam logic [11:0] APB_LAST_OFS   = 12'h008;
  // Vector addresses
  localparam logic [31:0] VEC_RESET      = 32'h00000000;
  localparam logic [31:0] VEC_NMI        = 32'h00000010;
  localparam logic [31:0] VEC_TRAP_A     = 32'h00000040;
  localparam logic [31:0] VEC_TRAP_B     = 32'h00000050;
  localparam logic [31:0] VEC_ILLEGAL    = 32'h00000060;
  localparam logic [31:0] VEC_TIMER_OVF  = 32'h00000080;
  localparam logic [31:0] VEC_CONV_DONE  = 32'h00000400;
  localparam logic [31:0] VEC_STEP       = 32'h00000010;
  localparam int          NUM_CS         = 8;
  localparam int          CS_SHIFT       = 23;
  typedef enum logic [2:0] {
    EXC_RESET   = 3'h0,
    EXC_NMI     = 3'h1,
    EXC_TRAP_A  = 3'h2,
    EXC_TRAP_B  = 3'h3,
    EXC_ILLEGAL = 3'h4,
    EXC_PERIPH  = 3'h5
  } amd_exc_t;
  typedef enum logic [1:0] {
    WS_IDLE = 2'b00,
    WS_LOW  = 2'b01,
    WS_HIGH = 2'b10
  } amd_word_t;
endpackage

// file: amd_periph_model.sv
// Purpose: Peripheral register model on the halfword bus
// Assumes: Offsets below 060 are byte-wide registers
// Notes:   Idle bus and undefined bytes show a changing pattern
`timescale 1ns/1ps
module amd_periph_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Halfword bus
  input  wire logic        perReq,
  input  wire logic        perWrite,
  input  wire logic [11:0] perAddr,
  input  wire logic [15:0] perWdata,
  output logic [15:0]      perRdata,
  output logic             perIsByteReg
);
  logic [15:0] mem [0:2047];
  logic [15:0] junkReg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      junkReg <= 16'h5A3C;
    end else begin
      junkReg <= ~junkReg + 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (perReq && perWrite) begin
      mem[perAddr[11:1]] <= perWdata;
    end
  end
  assign perIsByteReg = perAddr < 12'h060;
  // Never a stale value, so a missed byte mask shows up
  assign perRdata = !perReq ? junkReg :
                    perIsByteReg ? {junkReg[7:0], mem[perAddr[11:1]][7:0]} : mem[perAddr[11:1]];
endmodule

// file: tb_top.sv
// Purpose: Self-checking bench for the address map decoder
// Assumes: Zero-wait APB, straps only changed in reset
// Notes:   Reads are checked from queues by a monitor
`timescale 1ns/1ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import amd_pkg::*;
  logic              clk, rst, strapSelectLow, strapSelectHigh, psel, penable, pwrite, pready, pslverr;
  logic [11:0]       paddr, perAddr;
  logic [3:0]        pstrb;
  logic [31:0]       pwdata, prdata, dataBase, dataDisp, dataWdata, dataRdata, pcBase, pcOffset;
  logic [31:0]       pcTarget, vectorAddr, a, s;
  logic              dataReq, dataWrite, dataDone, pcInPeriph, excReq, vectorValid, ram, ext, rdPend;
  logic [1:0]        dataSize;
  amd_exc_t          excKind;
  logic [6:0]        periphIndex;
  logic [25:0]       physAddr, p;
  logic              selRam, selPeriph, extStart, perReq, perWrite, perByteReg, perIsByteReg;
  logic [NUM_CS-1:0] chipSel, cs;
  logic [15:0]       perWdata, perRdata;
  logic [7:0]        expansionPinControl, upperAddrEnable;
  logic              upperDataIsBus, modeProhibited, busWide16;
  int                miscompares, nCompared, cycles;
  logic [32:0]       apbQ[$];
  logic [31:0]       dataQ[$];
  logic [32:0]       expApb;
  logic [31:0]       expData;
  logic [25:0]       bnd[10] = '{26'h0, 26'h0FFFFFF, 26'h1000000, 26'h2FFFFFF, 26'h3000000, 26'h37FFFFF,
                                 26'h3800000, 26'h3FFDFFF, 26'h3FFE000, 26'h3FFEFFF};
  logic [31:0]       vec[8] = '{VEC_RESET, VEC_NMI, VEC_TRAP_A, VEC_TRAP_B, VEC_ILLEGAL, VEC_TIMER_OVF,
                                32'h00000090, VEC_CONV_DONE};
  amd_address_map_decoder DUT (
    .clk, .rst, .strapSelectLow, .strapSelectHigh, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .dataReq, .dataWrite, .dataSize, .dataBase, .dataDisp, .dataWdata,
    .dataRdata, .dataDone, .pcBase, .pcOffset, .pcTarget, .pcInPeriph, .excReq, .excKind, .periphIndex,
    .vectorAddr, .vectorValid, .physAddr, .selRam, .selPeriph, .extStart, .chipSel, .perReq, .perWrite,
    .perAddr, .perWdata, .perByteReg, .perRdata, .perIsByteReg, .expansionPinControl, .upperDataIsBus,
    .upperAddrEnable, .modeProhibited, .busWide16);
  amd_periph_model PM (.clk, .rst, .perReq, .perWrite, .perAddr, .perWdata, .perRdata, .perIsByteReg);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic finishTest();
    if (miscompares == 0 && nCompared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finishTest();
    end
  end
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      expApb = apbQ.pop_front();
      `CHK({pslverr, prdata}, expApb)
    end
    if (rdPend) begin
      expData = dataQ.pop_front();
      `CHK(dataRdata, expData)
    end
    rdPend <= dataReq && dataDone && !dataWrite;
  end
  task automatic doReset(input logic lo, input logic hi);
    rst <= 1'b1;
    strapSelectLow <= lo;
    strapSelectHigh <= hi;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d, input logic [3:0] st,
                     input logic [32:0] e);
    int n;
    if (!wr) apbQ.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (!pready && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic dacc(input logic wr, input logic [1:0] sz, input logic [31:0] ad, input logic [31:0] d,
                      input logic [31:0] e);
    int n;
    logic [31:0] off;
    off = $urandom;
    if (!wr) dataQ.push_back(e);
    dataReq <= 1'b1;
    dataWrite <= wr;
    dataSize <= sz;
    dataBase <= ad - off;
    dataDisp <= off;
    dataWdata <= d;
    @(negedge clk);
    `CHK({selPeriph, extStart, physAddr}, {2'b10, ad[25:0]})
    n = 0;
    do begin @(posedge clk); n++; end while (!dataDone && n < 20);
    dataReq <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    {rst, strapSelectLow, strapSelectHigh, psel, penable, pwrite, dataReq, dataWrite, excReq} = 9'h100;
    {paddr, pstrb, pwdata, dataSize, dataBase, dataDisp, dataWdata, pcBase, pcOffset, periphIndex} = '0;
    excKind = EXC_RESET;
    {miscompares, nCompared, cycles, rdPend} = '0;
    void'($urandom(32'hBD87));
    doReset(1'b0, 1'b0);
    `CHK({expansionPinControl, busWide16, upperDataIsBus, upperAddrEnable}, {EXP_RESET_M0, 2'b11, 8'hFF})
    apb(1'b0, APB_EXP_OFS, 32'h0, 4'h0, {1'b0, 32'h07});
    apb(1'b1, APB_EXP_OFS, 32'hFFFFFFFF, 4'hF, '0);
    apb(1'b0, APB_EXP_OFS, 32'h0, 4'h0, {1'b0, 32'h0F});
    `CHK({upperDataIsBus, upperAddrEnable}, {1'b0, 8'hFF})
    apb(1'b1, APB_EXP_OFS, 32'h0, 4'hF, '0);
    apb(1'b1, APB_EXP_OFS, 32'h07, 4'hE, '0);
    apb(1'b0, APB_EXP_OFS, 32'h0, 4'h0, {1'b0, 32'h00});
    `CHK({upperDataIsBus, upperAddrEnable}, {1'b1, 8'h00})
    apb(1'b0, APB_LAST_OFS, 32'h0, 4'h0, {1'b1, 32'h0});
    apb(1'b0, 12'hFFC, 32'h0, 4'h0, {1'b1, 32'h0});
    for (int i = 0; i < 30; i++) begin
      a = $urandom;
      if (i < 10) a[25:0] = bnd[i];
      if (a[25:12] == 14'h3FFF) a[12] = 1'b0;
      s = $urandom;
      dataReq <= 1'b1;
      dataWrite <= 1'b1;
      dataBase <= a - s;
      dataDisp <= s;
      @(negedge clk);
      p = a[25:0];
      ram = p >= RAM_BASE && p <= RAM_LAST;
      ext = !ram && p <= EXT_LAST && !(p >= RSV_BASE && p <= RSV_LAST);
      cs = (ext && p[25:23] != 3'h7) ? NUM_CS'(1) << p[25:23] : '0;
      `CHK({physAddr, selRam, selPeriph, extStart, chipSel}, {p, ram, 1'b0, ext, cs})
      @(posedge clk);
    end
    dataReq <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      a = (i == 0) ? 32'h03FFFFF0 : (i == 1) ? 32'h03FFF000 : $urandom;
      s = (i < 2) ? 32'h20 * (1 - i) : $urandom;
      pcBase <= a;
      pcOffset <= s;
      s = a + s;
      @(negedge clk);
      `CHK({pcTarget, pcInPeriph}, {6'h0, s[25:1], 1'b0, s[25:0] >= PIO_BASE})
      @(posedge clk);
    end
    excReq <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      excKind <= (k < 5) ? amd_exc_t'(k) : EXC_PERIPH;
      periphIndex <= (k == 7) ? 7'h38 : (k == 6) ? 7'h01 : 7'h00;
      @(negedge clk);
      `CHK({vectorValid, vectorAddr}, {1'b1, vec[k]})
      @(posedge clk);
    end
    excReq <= 1'b0;
    dacc(1'b1, 2'd1, 32'hFFFFF060, 32'h1234, '0);
    dacc(1'b1, 2'd1, 32'h03FFF062, 32'h5678, '0);
    dacc(1'b0, 2'd2, 32'hFFFFF061, '0, 32'h56781234);
    dacc(1'b1, 2'd1, 32'hFFFFF052, 32'hC3A5, '0);
    dacc(1'b0, 2'd1, 32'hFFFFF052, '0, 32'h000000A5);
    dacc(1'b0, 2'd0, 32'hFFFFF053, '0, 32'h000000A5);
    doReset(1'b1, 1'b0);
    `CHK({expansionPinControl, busWide16, upperDataIsBus, upperAddrEnable}, {EXP_RESET_M1, 2'b00, 8'hFF})
    apb(1'b0, APB_EXP_OFS, 32'h0, 4'h0, {1'b0, 32'h0F});
    doReset(1'b0, 1'b1);
    `CHK(modeProhibited, 1'b1)
    finishTest();
  end
endmodule
